// ### design/rtf_pkg.sv
package rtf_pkg;
   localparam logic [7:0] A_TAIL = 8'h2e;
   localparam logic [7:0] A_PULSE = 8'h2f;
   localparam logic [7:0] A_BURST = 8'h30;
   localparam logic [7:0] A_WAIT = 8'h31;
   localparam logic [7:0] A_WAITLO = 8'h32;
   localparam logic [7:0] A_PERIOD = 8'h3c;
   localparam logic [7:0] A_MODCFG = 8'h3d;
   localparam logic [7:0] A_STATUS = 8'h3e;
   localparam logic [7:0] WAIT_RST = 8'hc0;
   localparam logic [7:0] PERIOD_RST = 8'h7f;
   localparam logic [7:0] TAIL_MASK = 8'h1f;
   localparam logic [7:0] BURST_MASK = 8'h77;
   localparam logic [7:0] MODCFG_MASK = 8'h1f;
   localparam int GRID_B = 4;
   localparam int PAY_B = 3;
   localparam int LAST_L = 0;
   localparam int SYM1_L = 4;
   localparam int SYM0_L = 0;
   localparam int ORIG_B = 7;
   localparam int UNIT_B = 6;
   localparam int WHI_L = 3;
   localparam int STOP_L = 0;
   localparam int MIL_B = 0;
   localparam int POS_B = 1;
   localparam int LVL_B = 2;
   localparam int SYM_B = 3;
   localparam int TYB_B = 4;
   localparam logic [7:0] UNIT16_LAST = 8'h0f;
   // Carrier 13.56 MHz against the 125 MHz clock, in kHz
   localparam logic [17:0] CLK_KHZ = 18'h1e848;
   localparam logic [17:0] CARR_KHZ = 18'h034f8;
   localparam int FIFO_DEPTH = 32;

   typedef enum logic [3:0] {
      S_IDLE = 4'h1,
      S_GRID = 4'h2,
      S_DATA = 4'h4,
      S_BURST = 4'h8
   } rtf_state_e;

   typedef struct packed {
      logic last;
      logic [7:0] data;
   } rtf_byte_s;

   typedef struct packed {
      logic [7:0] tail;
      logic [7:0] pulse;
      logic [7:0] burst;
      logic [7:0] waitc;
      logic [7:0] waitlo;
      logic [7:0] period;
      logic [7:0] modcfg;
      rtf_state_e st;
      logic [17:0] acc;
      logic ctick;
      logic pend;
      logic [10:0] gcnt;
      logic [7:0] gunit;
      logic [7:0] phase;
      logic [7:0] bcnt;
      logic [8:0] nbits;
      logic [7:0] sh;
      logic last;
      logic stop;
      logic lvl;
      logic [8:0] pcnt;
      logic mod;
      logic busy;
      logic done;
      logic [7:0] rdata;
   } rtf_top_s;

   function automatic logic [8:0] rtf_burst_bits(input logic [2:0] code);
      logic [8:0] b;
      b = 9'h008;
      unique case (code)
         3'h0: b = 9'h008;
         3'h1: b = 9'h010;
         3'h2: b = 9'h020;
         3'h3: b = 9'h030;
         3'h4: b = 9'h040;
         3'h5: b = 9'h060;
         3'h6: b = 9'h080;
         3'h7: b = 9'h100;
      endcase
      return b;
   endfunction : rtf_burst_bits
endpackage : rtf_pkg

// ### design/rtf_frame_timing.sv
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
module rtf_fifo
   import rtf_pkg::*;
#(
   parameter int WIDTH = 9,
   parameter int DEPTH = FIFO_DEPTH
)
(
   input wire logic clk,
   input wire logic rst,
   input wire logic [WIDTH-1:0] in_data,
   input wire logic in_valid,
   output logic in_ready,
   output logic [WIDTH-1:0] out_data,
   output logic out_valid,
   input wire logic out_ready
);
   localparam int AW = $clog2(DEPTH);

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW-1:0] wr;
      logic [AW-1:0] rd;
      logic [AW:0] cnt;
      logic rdy;
   } rtf_fifo_s;

   rtf_fifo_s f_reg;
   rtf_fifo_s f_next;
   logic push;
   logic pop;

   always_comb
   begin
      f_next = f_reg;
      push = in_valid && f_reg.rdy;
      pop = out_ready && (f_reg.cnt != '0);
      if (push)
      begin
         f_next.mem[f_reg.wr] = in_data;
         f_next.wr = f_reg.wr + 1'b1;
      end
      if (pop)
         f_next.rd = f_reg.rd + 1'b1;
      f_next.cnt = f_reg.cnt + (AW+1)'(push) - (AW+1)'(pop);
      // Ready is registered so the top can hand it out straight
      f_next.rdy = f_next.cnt != (AW+1)'(DEPTH);
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         f_reg <= '{rdy: 1'b1, default: '0};
      else
         f_reg <= f_next;
   end

   assign in_ready = f_reg.rdy;
   assign out_data = f_reg.mem[f_reg.rd];
   assign out_valid = f_reg.cnt != '0;
endmodule : rtf_fifo

////////////////////////////////////////////////////////////////////////////////
// Notes on behaviour
// - With grid alignment set, starts are spaced by whole bit periods.
// - With grid alignment clear, a start may happen on any clock cycle.
// - Payload flag set sends data bytes; clear sends one symbol pattern.
// - Final byte bit count sets bits sent of last byte; zero means eight.
// - Bytes go out LSB first; truncation drops the top bits.
// - Miller pulse lasts pulse length plus one carrier periods.
// - A pulse never runs past the end of its bit.
// - Pulse start within the bit follows the pulse position select.
// - Pulse length used only under Miller data bits; start/stop symbol bursts ignore it.
// - Burst is unmodulated, held at the burst level for its length.
// - Symbol one burst length from code: 8,16,32,48,64,96,128,256 bits.
// - Symbol zero burst length uses the same eight-step code.
// - Guard wait starts at end of send, or end of receive when set.
// - Guard unit is 16 carrier periods, or half a bit period when set.
// - Upper three wait bits extend the low wait byte as MSBs.
// - Wait control register resets to c0.
// - Guard wait count is eleven bits, minimum gap before a send.
// - Type B: stop field gives no stop, one stop, or stop plus guards.
module rtf_frame_timing
   import rtf_pkg::*;
(
   input wire logic REF_CLK,
   input wire logic RST,
   input wire logic [7:0] REG_ADDR,
   input wire logic [7:0] REG_WDATA,
   input wire logic REG_WR,
   input wire logic REG_RD,
   output logic [7:0] REG_RDATA,
   input wire logic [7:0] DIN_DATA,
   input wire logic DIN_LAST,
   input wire logic DIN_VALID,
   output logic DIN_READY,
   input wire logic TX_START,
   input wire logic RX_END,
   output logic TX_MOD,
   output logic TX_BUSY,
   output logic TX_DONE
);
   rtf_top_s st_reg;
   rtf_top_s st_next;
   rtf_byte_s fifo_rd;
   logic fifo_valid;
   logic pop;
   logic start;
   logic load;
   logic finish;
   logic bit_end;
   logic [17:0] acc_sum;
   logic [10:0] gwait;
   logic [7:0] unit_last;
   logic [7:0] pstart;
   logic [2:0] nlast;

   rtf_fifo #(
      .WIDTH($bits(rtf_byte_s)),
      .DEPTH(FIFO_DEPTH)
   ) rtf_fifo_i (
      .clk(REF_CLK),
      .rst(RST),
      .in_data({DIN_LAST, DIN_DATA}),
      .in_valid(DIN_VALID),
      .in_ready(DIN_READY),
      .out_data(fifo_rd),
      .out_valid(fifo_valid),
      .out_ready(pop)
   );

   ////////////////////////////////////////////////////////////////////////////
   always_comb
   begin
      st_next = st_reg;
      pop = 1'b0;
      start = 1'b0;
      load = 1'b0;
      finish = 1'b0;
      st_next.done = 1'b0;
      st_next.rdata = 8'h00;
      // Fractional divider: carrier tick enable at 13.56 MHz average
      acc_sum = st_reg.acc + CARR_KHZ;
      st_next.ctick = acc_sum >= CLK_KHZ;
      st_next.acc = st_next.ctick ? acc_sum - CLK_KHZ : acc_sum;
      bit_end = st_reg.ctick && (st_reg.bcnt >= st_reg.period);
      gwait = {st_reg.waitc[WHI_L +: 3], st_reg.waitlo};
      unit_last = st_reg.waitc[UNIT_B] ? {1'b0, st_reg.period[7:1]} : UNIT16_LAST;
      pstart = st_reg.modcfg[POS_B] ? {1'b0, st_reg.period[7:1]} : 8'h00;
      nlast = st_reg.tail[LAST_L +: 3];

      if (REG_WR)
      begin
         unique case (REG_ADDR)
            A_TAIL: st_next.tail = REG_WDATA & TAIL_MASK;
            A_PULSE: st_next.pulse = REG_WDATA;
            A_BURST: st_next.burst = REG_WDATA & BURST_MASK;
            A_WAIT: st_next.waitc = REG_WDATA;
            A_WAITLO: st_next.waitlo = REG_WDATA;
            A_PERIOD: st_next.period = REG_WDATA;
            A_MODCFG: st_next.modcfg = REG_WDATA & MODCFG_MASK;
            default: ;
         endcase
      end
      if (REG_RD)
      begin
         unique case (REG_ADDR)
            A_TAIL: st_next.rdata = st_reg.tail;
            A_PULSE: st_next.rdata = st_reg.pulse;
            A_BURST: st_next.rdata = st_reg.burst;
            A_WAIT: st_next.rdata = st_reg.waitc;
            A_WAITLO: st_next.rdata = st_reg.waitlo;
            A_PERIOD: st_next.rdata = st_reg.period;
            A_MODCFG: st_next.rdata = st_reg.modcfg;
            A_STATUS: st_next.rdata = {4'h0, fifo_valid, st_reg.gcnt != '0,
                                       st_reg.pend, st_reg.busy};
            default: st_next.rdata = 8'h00;
         endcase
      end

      // Guard wait countdown in units of 16 carrier ticks or half bits
      if (st_reg.ctick && st_reg.gcnt != '0)
      begin
         if (st_reg.gunit >= unit_last)
         begin
            st_next.gunit = 8'h00;
            st_next.gcnt = st_reg.gcnt - 11'h001;
         end
         else
            st_next.gunit = st_reg.gunit + 8'h01;
      end
      if (RX_END && st_reg.waitc[ORIG_B])
      begin
         st_next.gcnt = gwait;
         st_next.gunit = 8'h00;
      end

      if (st_reg.ctick)
         st_next.phase = (st_reg.phase >= st_reg.period) ? 8'h00 : st_reg.phase + 8'h01;

      unique case (st_reg.st)
         S_IDLE:
         begin
            if (st_reg.pend && st_reg.gcnt == '0)
               st_next.st = S_GRID;
         end
         S_GRID:
         begin
            // Phase restarts at every start, so aligned starts land on ETU edges
            if ((!st_reg.tail[GRID_B] || (st_reg.ctick && st_reg.phase >= st_reg.period))
                && (!st_reg.tail[PAY_B] || fifo_valid) && st_reg.gcnt == '0)
            begin
               start = 1'b1;
               st_next.pend = 1'b0;
               st_next.busy = 1'b1;
               st_next.phase = 8'h00;
               st_next.bcnt = 8'h00;
               if (st_reg.tail[PAY_B])
                  load = 1'b1;
               else
               begin
                  st_next.st = S_BURST;
                  st_next.stop = 1'b0;
                  st_next.lvl = st_reg.modcfg[LVL_B];
                  st_next.nbits = rtf_burst_bits(st_reg.modcfg[SYM_B] ?
                     st_reg.burst[SYM1_L +: 3] : st_reg.burst[SYM0_L +: 3]);
               end
            end
         end
         S_DATA:
         begin
            if (bit_end)
            begin
               st_next.bcnt = 8'h00;
               st_next.sh = st_reg.sh >> 1;
               st_next.nbits = st_reg.nbits - 9'h001;
               if (st_reg.nbits <= 9'h001)
               begin
                  if (!st_reg.last && fifo_valid)
                     load = 1'b1;
                  else if (st_reg.last && st_reg.modcfg[TYB_B]
                           && st_reg.waitc[STOP_L +: 3] != 3'h0)
                  begin
                     // One stop bit plus the extra guard times, held high
                     st_next.st = S_BURST;
                     st_next.stop = 1'b1;
                     st_next.lvl = 1'b1;
                     st_next.nbits = {6'h00, st_reg.waitc[STOP_L +: 3]};
                  end
                  else
                     finish = 1'b1;
               end
            end
            else if (st_reg.ctick)
               st_next.bcnt = st_reg.bcnt + 8'h01;
         end
         S_BURST:
         begin
            if (bit_end)
            begin
               st_next.bcnt = 8'h00;
               st_next.nbits = st_reg.nbits - 9'h001;
               if (st_reg.nbits <= 9'h001)
                  finish = 1'b1;
            end
            else if (st_reg.ctick)
               st_next.bcnt = st_reg.bcnt + 8'h01;
         end
         default: st_next.st = S_IDLE;
      endcase

      if (load)
      begin
         // An underrun before the last byte simply ends the frame
         pop = 1'b1;
         st_next.st = S_DATA;
         st_next.sh = fifo_rd.data;
         st_next.last = fifo_rd.last;
         st_next.nbits = (fifo_rd.last && nlast != 3'h0) ? {6'h00, nlast} : 9'h008;
      end
      if (finish)
      begin
         st_next.st = S_IDLE;
         st_next.busy = 1'b0;
         st_next.done = 1'b1;
         st_next.bcnt = 8'h00;
         if (!st_reg.waitc[ORIG_B])
         begin
            st_next.gcnt = gwait;
            st_next.gunit = 8'h00;
         end
      end
      // Set wins over the clear taken at start
      if (TX_START)
         st_next.pend = 1'b1;

      // Modulation output; pulse counter is cleared at each bit edge
      st_next.pcnt = 9'h000;
      if (st_next.st == S_DATA && st_reg.modcfg[MIL_B])
      begin
         if (!(bit_end || start || load) && st_reg.ctick && st_reg.pcnt != '0)
            st_next.pcnt = st_reg.pcnt - 9'h001;
         else if (!(bit_end || start || load))
            st_next.pcnt = st_reg.pcnt;
         if ((st_reg.ctick || start || load) && st_next.bcnt == pstart
             && !st_next.sh[0])
            st_next.pcnt = {1'b0, st_reg.pulse} + 9'h001;
         st_next.mod = st_next.pcnt != '0;
      end
      else if (st_next.st == S_DATA)
         st_next.mod = st_next.sh[0];
      else if (st_next.st == S_BURST)
         st_next.mod = st_next.lvl;
      else
         st_next.mod = 1'b0;
   end

   always_ff @(posedge REF_CLK or posedge RST)
   begin
      if (RST)
         st_reg <= '{waitc: WAIT_RST, period: PERIOD_RST, st: S_IDLE, default: '0};
      else
         st_reg <= st_next;
   end

   assign REG_RDATA = st_reg.rdata;
   assign TX_MOD = st_reg.mod;
   assign TX_BUSY = st_reg.busy;
   assign TX_DONE = st_reg.done;

   ////////////////////////////////////////////////////////////////////////////
   default clocking dc @(posedge REF_CLK);
   endclocking
   default disable iff (RST);

   a_guard_clear: assert property (
      $rose(st_reg.busy) |-> $past(st_reg.gcnt) == '0)
      else $error("send started during guard wait");
   a_grid_start: assert property (
      $rose(st_reg.busy) && $past(st_reg.tail[GRID_B])
      |-> $past(st_reg.ctick) && $past(st_reg.phase) >= $past(st_reg.period))
      else $error("aligned start off the bit grid");
   a_free_start: assert property (
      st_reg.st == S_GRID && !st_reg.tail[GRID_B] && !st_reg.tail[PAY_B] && st_reg.gcnt == '0
      |=> st_reg.busy && st_reg.st == S_BURST)
      else $error("unaligned symbol start delayed");
   a_last_count: assert property (
      pop && fifo_rd.last && nlast != 3'h0 |=> st_reg.nbits == {6'h00, $past(nlast)})
      else $error("final byte bit count wrong");
   a_pulse_width: assert property (
      $rose(st_reg.mod) && st_reg.st == S_DATA && st_reg.modcfg[MIL_B]
      |-> st_reg.pcnt == {1'b0, st_reg.pulse} + 9'h001)
      else $error("pulse length wrong");
   a_pulse_clip: assert property (
      st_reg.st == S_DATA && st_next.st == S_DATA && bit_end && st_reg.modcfg[MIL_B]
      && st_reg.modcfg[POS_B] && st_reg.period > 8'h01 |=> !st_reg.mod)
      else $error("pulse crossed bit edge");
   a_nrz_data: assert property (
      st_reg.st == S_DATA && !st_reg.modcfg[MIL_B] |-> st_reg.mod == st_reg.sh[0])
      else $error("pulse used without Miller");
   a_burst_level: assert property (
      st_reg.st == S_BURST |-> st_reg.mod == st_reg.lvl)
      else $error("burst level wrong");
   a_burst_len: assert property (
      $past(st_reg.st) == S_GRID && st_reg.st == S_BURST |-> st_reg.nbits ==
      rtf_burst_bits(st_reg.modcfg[SYM_B] ? st_reg.burst[SYM1_L +: 3] : st_reg.burst[SYM0_L +: 3]))
      else $error("burst length wrong");
   a_guard_load: assert property (
      st_reg.done && !st_reg.waitc[ORIG_B] |-> st_reg.gcnt == gwait)
      else $error("guard not loaded at send end");
   a_wait_write: assert property (
      $changed(st_reg.waitc) |-> $past(REG_WR) && $past(REG_ADDR) == A_WAIT)
      else $error("wait control changed unbidden");

   c_grid_start: cover property ($rose(st_reg.busy) && st_reg.tail[GRID_B]);
   c_symbol: cover property (st_reg.st == S_BURST && !st_reg.stop);
   c_stop_tail: cover property (st_reg.st == S_BURST && st_reg.stop ##1 st_reg.done);
endmodule : rtf_frame_timing

// ### testbench/rtf_card_model.sv
`timescale 1ns/1ps

////////////////////////////////////////////////////////////
// Card side: ends its reply a set time after each frame
module rtf_card_model
   import rtf_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic tx_busy,
   input wire logic [15:0] reply_delay,
   output logic rx_end
);
   logic busy_q;
   logic [15:0] cnt;

   // A delay of zero keeps the card silent
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         busy_q <= 1'b0;
         cnt <= 16'h0000;
         rx_end <= 1'b0;
      end
      else
      begin
         busy_q <= tx_busy;
         rx_end <= (cnt == 16'h0001);
         if (busy_q && !tx_busy)
            cnt <= reply_delay;
         else if (cnt != 16'h0000)
            cnt <= cnt - 16'h0001;
      end
   end
endmodule : rtf_card_model

// ### testbench/rtf_frame_timing_bench.sv
`timescale 1ns/1ps

module rtf_frame_timing_bench
   import rtf_pkg::*;
;
   logic REF_CLK = 1'b0;
   logic RST = 1'b1;
   logic [7:0] REG_ADDR = 8'h00;
   logic [7:0] REG_WDATA = 8'h00;
   logic REG_WR = 1'b0;
   logic REG_RD = 1'b0;
   logic [7:0] REG_RDATA;
   logic [7:0] DIN_DATA = 8'h00;
   logic DIN_LAST = 1'b0;
   logic DIN_VALID = 1'b0;
   logic DIN_READY;
   logic TX_START = 1'b0;
   logic RX_END;
   logic TX_MOD;
   logic TX_BUSY;
   logic TX_DONE;
   logic [15:0] reply_delay = 16'h0003;
   // Non-aligned starts fall up to one carrier tick before the first counted tick
   int mismatches = 0;
   int checks = 0;
   int lead;
   int start_t;
   int cyc = 0;
   logic q[$];
   logic [7:0] ra[8] = '{8'h2e, 8'h2f, 8'h30, 8'h31, 8'h32, 8'h3c, 8'h3d, 8'h40};
   logic [7:0] rx[8] = '{8'h1f, 8'hff, 8'h77, 8'hff, 8'hff, 8'hff, 8'h1f, 8'h00};
   int dn[4] = '{1, 1, 1, 32};
   logic [7:0] db[4] = '{8'hb2, 8'hb2, 8'hb2, 8'h5a};
   logic [2:0] dl[4] = '{3'h3, 3'h6, 3'h0, 3'h5};
   int dbits[4] = '{3, 6, 8, 253};
   logic [7:0] mc[5] = '{8'h00, 8'h01, 8'h03, 8'h01, 8'h03};
   logic [7:0] pw[5] = '{8'h03, 8'h03, 8'h03, 8'hff, 8'hff};
   int mr[5] = '{0, 8, 11, 8, 11};
   int ml[5] = '{8, 4, 4, 8, 5};
   int bl[8] = '{8, 16, 32, 48, 64, 96, 128, 256};
   logic [7:0] gc[3] = '{8'h00, 8'h48, 8'h80};
   logic [7:0] gl[3] = '{8'h0a, 8'h00, 8'h0a};
   int gt[3] = '{160, 512, 160};

   rtf_frame_timing rtf_frame_timing_i (.REF_CLK(REF_CLK), .RST(RST), .REG_ADDR(REG_ADDR),
      .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA),
      .DIN_DATA(DIN_DATA), .DIN_LAST(DIN_LAST), .DIN_VALID(DIN_VALID),
      .DIN_READY(DIN_READY), .TX_START(TX_START), .RX_END(RX_END), .TX_MOD(TX_MOD),
      .TX_BUSY(TX_BUSY), .TX_DONE(TX_DONE));

   rtf_card_model rtf_card_model_i (.clk(REF_CLK), .rst(RST), .tx_busy(TX_BUSY),
      .reply_delay(reply_delay), .rx_end(RX_END));

   initial
   begin
      forever #4 REF_CLK = ~REF_CLK;
   end

   always @(posedge REF_CLK) cyc <= cyc + 1;

   ////////////////////////////////////////////////////////////
   task automatic wrap_up();
      $display("Comparisons %0d, mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : wrap_up

   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("ERROR %s expected %0h seen %0h", nm, exp, seen);
      end
   endtask : check

   // Carrier ticks fall every 9 or 10 clocks, so times are judged with a margin
   task automatic chk_near(input string nm, input real s, input real e, input real t);
      check(nm, (s - e <= t && e - s <= t) ? $rtoi(e) : $rtoi(s), $rtoi(e));
   endtask : chk_near

   function automatic real tk(input real t);
      return t * 125000.0 / 13560.0;
   endfunction : tk

   task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
      REG_ADDR <= a;
      REG_WDATA <= d;
      REG_WR <= 1'b1;
      @(posedge REF_CLK);
      REG_WR <= 1'b0;
      @(posedge REF_CLK);
   endtask : reg_wr

   task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
      REG_ADDR <= a;
      REG_RD <= 1'b1;
      @(posedge REF_CLK);
      REG_RD <= 1'b0;
      @(posedge REF_CLK);
      check($sformatf("reg %0h", a), REG_RDATA, e);
   endtask : rd_chk

   // A full load keeps offering so that a byte taken past full would show up in k
   task automatic push(input int n, input logic [7:0] base, output int k);
      k = 0;
      for (int i = 0; i < n + 8; i++)
      begin
         DIN_VALID <= (k < n) || (n == FIFO_DEPTH);
         DIN_DATA <= base ^ 8'(k);
         DIN_LAST <= (k == n - 1);
         @(posedge REF_CLK);
         if (DIN_VALID === 1'b1 && DIN_READY === 1'b1)
            k++;
      end
      DIN_VALID <= 1'b0;
   endtask : push

   task automatic run_frame();
      int n;
      q.delete();
      TX_START <= 1'b1;
      @(posedge REF_CLK);
      TX_START <= 1'b0;
      n = 0;
      while (TX_BUSY !== 1'b1 && n < 40000)
      begin
         @(posedge REF_CLK);
         n++;
      end
      lead = n;
      start_t = cyc;
      while (TX_BUSY === 1'b1 && n < 80000)
      begin
         q.push_back(TX_MOD);
         @(posedge REF_CLK);
         n++;
      end
      if (n >= 40000)
      begin
         mismatches++;
         $display("ERROR frame wait expected end seen timeout");
         wrap_up();
      end
      else
         check("done pulse", TX_DONE, 1'b1);
   endtask : run_frame

   ////////////////////////////////////////////////////////////
   initial
   begin : main
      int k;
      int nb;
      real e;
      logic [7:0] b;
      int st[3];
      repeat (10) @(posedge REF_CLK);
      RST <= 1'b0;
      @(posedge REF_CLK);
      rd_chk(A_WAIT, 8'hc0);
      rd_chk(A_PERIOD, 8'h7f);
      foreach (ra[i]) reg_wr(ra[i], 8'hff);
      foreach (ra[i]) rd_chk(ra[i], rx[i]);
      reg_wr(A_PERIOD, 8'h03);
      reg_wr(A_MODCFG, 8'h00);
      reg_wr(A_WAIT, 8'h00);
      reg_wr(A_WAITLO, 8'h00);
      foreach (dn[r])
      begin
         reg_wr(A_TAIL, {5'h01, dl[r]});
         push(dn[r], db[r], k);
         check("bytes taken", k, dn[r]);
         if (dn[r] == FIFO_DEPTH)
            rd_chk(A_STATUS, 8'h08);
         run_frame();
         chk_near("frame length", q.size(), tk(dbits[r] * 4 - 0.5), 7);
         for (int i = 0; i < dbits[r]; i++)
         begin
            b = db[r] ^ 8'(i / 8);
            check("data bit", q[$rtoi(tk(i * 4 + 2))], b[i % 8]);
         end
      end
      // Type B tail: five zero bits, then one stop bit and two guard times at level 1
      reg_wr(A_MODCFG, 8'h10);
      reg_wr(A_WAIT, 8'h03);
      push(1, 8'h00, k);
      run_frame();
      chk_near("stop tail length", q.size(), tk(31.5), 7);
      check("stop tail data", q[$rtoi(tk(10))], 1'b0);
      check("stop tail level", q[$rtoi(tk(26))], 1'b1);
      // Byte 55h puts an isolated zero bit second, so one pulse is measured alone
      reg_wr(A_PERIOD, 8'h07);
      foreach (mc[r])
      begin
         reg_wr(A_MODCFG, mc[r]);
         reg_wr(A_PULSE, pw[r]);
         push(1, 8'h55, k);
         run_frame();
         k = 0;
         while (k < q.size() && q[k] !== 1'b1) k++;
         chk_near("pulse start", k, tk(mr[r] - 0.5), 7);
         nb = k;
         while (nb < q.size() && q[nb] === 1'b1) nb++;
         e = (k == 0) ? tk(ml[r] - 0.5) : tk(ml[r]);
         chk_near("pulse width", nb - k, e, (k == 0) ? 7 : 3);
      end
      reg_wr(A_PERIOD, 8'h03);
      reg_wr(A_TAIL, 8'h00);
      for (int s = 0; s < 2; s++)
      begin
         for (int c = 0; c < 8; c++)
         begin
            reg_wr(A_MODCFG, (s == 1) ? 8'h08 : 8'h04);
            reg_wr(A_BURST, (s == 1) ? {1'b0, 3'(c), 1'b0, 3'(7 - c)}
                                     : {1'b0, 3'(7 - c), 1'b0, 3'(c)});
            run_frame();
            chk_near("burst length", q.size(), tk(bl[c] * 4 - 0.5), 8);
            check("burst level", q[q.size() / 2], (s == 1) ? 1'b0 : 1'b1);
         end
      end
      reg_wr(A_MODCFG, 8'h00);
      reg_wr(A_BURST, 8'h00);
      reply_delay <= 16'h00c8;
      foreach (gc[r])
      begin
         reg_wr(A_WAIT, gc[r]);
         reg_wr(A_WAITLO, gl[r]);
         run_frame();
         // With the receive origin the guard only runs from the card's reply
         if (gc[r][ORIG_B])
         begin
            nb = 0;
            while (RX_END !== 1'b1 && nb < 1000)
            begin
               @(posedge REF_CLK);
               nb++;
            end
            if (nb >= 1000)
            begin
               mismatches++;
               $display("ERROR card reply expected pulse seen timeout");
               wrap_up();
            end
         end
         run_frame();
         chk_near("guard gap", lead, tk(gt[r]), 16);
      end
      reg_wr(A_WAIT, 8'h00);
      reg_wr(A_WAITLO, 8'h00);
      run_frame();
      run_frame();
      chk_near("free start", lead, 7, 7);
      reg_wr(A_TAIL, 8'h10);
      for (int i = 0; i < 3; i++)
      begin
         repeat (i * 7 + 1) @(posedge REF_CLK);
         run_frame();
         st[i] = start_t;
      end
      e = tk(4);
      for (int i = 1; i < 3; i++)
      begin
         nb = $rtoi((st[i] - st[0]) / e + 0.5);
         chk_near("grid spacing", st[i] - st[0], nb * e, 2.5);
      end
      reg_wr(A_WAIT, 8'h12);
      RST <= 1'b1;
      repeat (3) @(posedge REF_CLK);
      RST <= 1'b0;
      @(posedge REF_CLK);
      check("ready after reset", DIN_READY, 1'b1);
      check("busy after reset", TX_BUSY, 1'b0);
      rd_chk(A_WAIT, 8'hc0);
      wrap_up();
   end
endmodule : rtf_frame_timing_bench
